// >>> core/oac_regs.sv
// apb register bank driving the operational amplifier core
module oac_regs
  import oac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog core
  input wire logic amp_output_level,
  output oac_analog_t amp_drive
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] trim;
    logic [31:0] rdata;
    logic err;
  } oac_state_t;
  oac_state_t st_reg;
  oac_state_t st_next;
  logic level_sync;
  oac_apb_req_t req;
  logic access;
  logic hit;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign access = req.psel && req.penable;

  // pin level crosses into the clock domain before anyone reads it
  oac_sync u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(amp_output_level),
    .sync_out(level_sync)
  );

  // address decode: three words mapped, anything else answers with an error
  always_comb begin
    hit = (req.paddr == OAC_CTRL_ADDR) || (req.paddr == OAC_TRIM_ADDR) ||
          (req.paddr == OAC_STAT_ADDR);
  end

  // register next state; read data lands on the setup edge, write data on the access edge
  always_comb begin
    st_next = st_reg;
    st_next.rdata = '0;
    st_next.err = 1'b0;
    if (req.psel && !req.penable) begin
      st_next.err = !hit;
      unique case (req.paddr)
        OAC_CTRL_ADDR: st_next.rdata = {24'h000000, st_reg.ctrl};
        OAC_TRIM_ADDR: st_next.rdata = {24'h000000, st_reg.trim};
        OAC_STAT_ADDR: st_next.rdata = {31'h00000000, level_sync};
        default: st_next.rdata = '0;
      endcase
    end else if (access) begin
      st_next.rdata = st_reg.rdata;
      st_next.err = st_reg.err;
    end
    if (access && req.pwrite) begin
      // masking drops the unused bits so they always read zero
      if (req.paddr == OAC_CTRL_ADDR) begin
        st_next.ctrl = req.pwdata[7:0] & OAC_CTRL_MASK;
      end
      // the whole trim byte is writable; ordering of mode and reference is software's job
      if (req.paddr == OAC_TRIM_ADDR) begin
        st_next.trim = req.pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '{ctrl: OAC_CTRL_RST, trim: OAC_TRIM_RST, rdata: 32'h00000000, err: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // apb answer: zero wait states, data captured during setup
  assign pready = 1'b1;
  assign prdata = access ? st_reg.rdata : 32'h00000000;
  assign pslverr = access && st_reg.err;

  // analog drive straight from the registers
  assign amp_drive.amp_power_on = st_reg.ctrl[OAC_POWER_BIT];
  assign amp_drive.amp_bandwidth_sel = st_reg.ctrl[OAC_BW_LSB +: 2];
  assign amp_drive.cal_mode_sel = st_reg.trim[OAC_MODE_BIT];
  assign amp_drive.cal_ref_input_sel = st_reg.trim[OAC_REF_BIT];
  assign amp_drive.offset_trim_code = st_reg.trim[OAC_TRIM_LSB +: 6];

  // control writes keep only the power and bandwidth bits
  a_ctrl_mask: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_reg.ctrl & ~OAC_CTRL_MASK) == 8'h00) else $error("unused control bits set");
  // a control write shows on the power pin one edge later
  a_power_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && paddr == OAC_CTRL_ADDR |=> amp_drive.amp_power_on == $past(pwdata[6]))
    else $error("power bit not taken");
  a_bw_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && paddr == OAC_CTRL_ADDR |=> amp_drive.amp_bandwidth_sel == $past(pwdata[1:0]))
    else $error("bandwidth not taken");
  a_mode_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && paddr == OAC_TRIM_ADDR |=> amp_drive.cal_mode_sel == $past(pwdata[7]))
    else $error("mode bit not taken");
  a_ref_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && paddr == OAC_TRIM_ADDR |=> amp_drive.cal_ref_input_sel == $past(pwdata[6]))
    else $error("reference bit not taken");
  a_trim_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && paddr == OAC_TRIM_ADDR |=> amp_drive.offset_trim_code == $past(pwdata[5:0]))
    else $error("trim code not taken");
  // the trim code holds when nothing writes it
  a_trim_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(access && pwrite && paddr == OAC_TRIM_ADDR) |=> $stable(amp_drive.offset_trim_code))
    else $error("trim code moved");
  // status read shows the pin level three edges before the access
  a_level_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == OAC_STAT_ADDR ##1 access
    |-> prdata[0] == $past(amp_output_level, 3)) else $error("level read wrong");

  // the remaining drive fields hold when no control or trim write lands
  a_power_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(access && pwrite && paddr == OAC_CTRL_ADDR) |=> $stable(amp_drive.amp_power_on))
    else $error("power bit moved");

  a_bw_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(access && pwrite && paddr == OAC_CTRL_ADDR) |=> $stable(amp_drive.amp_bandwidth_sel))
    else $error("bandwidth moved");

  a_mode_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(access && pwrite && paddr == OAC_TRIM_ADDR) |=> $stable(amp_drive.cal_mode_sel))
    else $error("mode bit moved");

  a_ref_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(access && pwrite && paddr == OAC_TRIM_ADDR) |=> $stable(amp_drive.cal_ref_input_sel))
    else $error("reference bit moved");

  // control read returns power and bandwidth as they stood at the setup edge
  a_ctrl_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == OAC_CTRL_ADDR ##1 access
    |-> prdata[7:0] == {1'b0, $past(amp_drive.amp_power_on), 4'h0,
                        $past(amp_drive.amp_bandwidth_sel)})
    else $error("control read wrong");

  // unused control positions and the upper word always read zero
  a_ctrl_zeros: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && !pwrite && paddr == OAC_CTRL_ADDR
    |-> prdata[31:8] == 24'h000000 && prdata[7] == 1'b0 && prdata[5:2] == 4'h0)
    else $error("unused control bits read");

  // trim read returns mode, reference and code as they stood at the setup edge
  a_trim_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == OAC_TRIM_ADDR ##1 access
    |-> prdata[7:0] == {$past(amp_drive.cal_mode_sel), $past(amp_drive.cal_ref_input_sel),
                        $past(amp_drive.offset_trim_code)})
    else $error("trim read wrong");

  a_trim_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && !pwrite && paddr == OAC_TRIM_ADDR |-> prdata[31:8] == 24'h000000)
    else $error("trim upper bits set");

  // status word carries only the level bit; software must not see stray ones
  a_stat_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && !pwrite && paddr == OAC_STAT_ADDR |-> prdata[31:1] == 31'h00000000)
    else $error("status upper bits set");

  // the status word is read only, a write to it changes no drive field
  a_stat_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && paddr == OAC_STAT_ADDR |=> $stable(amp_drive))
    else $error("status write changed drive");

  // a write to a hole must leave the analog drive alone
  a_hole_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && paddr != OAC_CTRL_ADDR && paddr != OAC_TRIM_ADDR
    |=> $stable(amp_drive))
    else $error("hole write changed drive");

  // holes answer with an error, mapped words never do
  a_err_hole: assert property (@(posedge sys_clk) disable iff (sys_rst)
    psel && !penable && paddr != OAC_CTRL_ADDR && paddr != OAC_TRIM_ADDR &&
    paddr != OAC_STAT_ADDR ##1 access |-> pslverr)
    else $error("hole gave no error");

  a_err_mapped: assert property (@(posedge sys_clk) disable iff (sys_rst)
    psel && !penable && (paddr == OAC_CTRL_ADDR || paddr == OAC_TRIM_ADDR ||
    paddr == OAC_STAT_ADDR) ##1 access |-> !pslverr)
    else $error("mapped word gave error");

  // outside the access phase the read bus and error stay quiet
  a_bus_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !access |-> prdata == 32'h00000000 && !pslverr)
    else $error("read bus not quiet");

  // zero wait states: every access phase ends on its first edge
  a_ready_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    access |-> pready)
    else $error("ready low in access");
endmodule

// >>> core/oac_pkg.sv
// package for the amplifier control register bank
package oac_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] OAC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] OAC_TRIM_ADDR = 8'h04;
  localparam logic [7:0] OAC_STAT_ADDR = 8'h08;
  // amp_control field positions
  localparam int OAC_POWER_BIT = 6;
  localparam int OAC_BW_LSB = 0;
  localparam logic [7:0] OAC_CTRL_MASK = 8'h43;
  // amp_offset_trim field positions
  localparam int OAC_MODE_BIT = 7;
  localparam int OAC_REF_BIT = 6;
  localparam int OAC_TRIM_LSB = 0;
  // reset values
  localparam logic [7:0] OAC_CTRL_RST = 8'h00;
  localparam logic [7:0] OAC_TRIM_RST = 8'h20;

  // apb request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } oac_apb_req_t;

  // drive toward the analog core
  typedef struct packed {
    logic amp_power_on;
    logic [1:0] amp_bandwidth_sel;
    logic cal_mode_sel;
    logic cal_ref_input_sel;
    logic [5:0] offset_trim_code;
  } oac_analog_t;
endpackage

// >>> core/oac_sync.sv
// two-stage synchroniser for the comparator-like amplifier output level
module oac_sync
  import oac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } oac_sync_state_t;
  oac_sync_state_t st_reg;
  oac_sync_state_t st_next;

  // first stage is read only by the second stage
  always_comb begin
    st_next = st_reg;
    st_next.meta = async_in;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stable;
endmodule

// >>> verification/oac_amp_model.sv
// behavioural amplifier core whose output trips at one trim code
module oac_amp_model
  import oac_pkg::*;
#(
  parameter int TRIP = 21
)(
  // drive in
  input wire oac_analog_t amp_drive,
  // level out
  output logic amp_output_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // switched off the output sits low, so a sweep then sees no edge
  assign amp_output_level = amp_drive.amp_power_on & (amp_drive.offset_trim_code >= TRIP);
endmodule

// >>> verification/tb.sv
// self-checking bench for the amplifier register bank
module tb
  import oac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TRIP = 21;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  oac_apb_req_t rq = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, lvl, e, l0;
  logic [5:0] v1, v2, c;
  oac_analog_t drv;
  int num_errors = 0;
  int checks = 0;
  // free running clock
  always #4 sys_clk = ~sys_clk;
  oac_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(rq.psel), .penable(rq.penable),
    .pwrite(rq.pwrite), .paddr(rq.paddr), .pwdata(rq.pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .amp_output_level(lvl), .amp_drive(drv));
  oac_amp_model #(.TRIP(TRIP)) amp (.amp_drive(drv), .amp_output_level(lvl));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rq <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    rq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    rq <= '0;
    if (pready !== 1'b1) begin
      num_errors++;
      close_out();
    end
    @(posedge sys_clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  // the wait covers the two-stage level synchroniser
  task automatic probe;
    xfer(1'b1, OAC_TRIM_ADDR, {24'h0, 2'b11, c});
    repeat (4) @(posedge sys_clk);
    xfer(1'b0, OAC_STAT_ADDR, 32'h0);
  endtask
  task automatic sweep(input logic [5:0] st, input logic up, output logic [5:0] v);
    c = st;
    probe();
    l0 = q[0];
    for (int k = 0; k < 63 && q[0] === l0; k++) begin
      c = up ? c + 6'h1 : c - 6'h1;
      probe();
    end
    v = c;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdc("ctrl rst", OAC_CTRL_ADDR, 32'h0);
    rdc("trim rst", OAC_TRIM_ADDR, 32'h20);
    chk("drive rst", {21'h0, drv}, 32'h20);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, OAC_CTRL_ADDR, {25'h1FFFFFF, i[2], 4'hF, i[1:0]});
      chk("power", drv.amp_power_on, i[2]);
      chk("bw", drv.amp_bandwidth_sel, i[1:0]);
      rdc("ctrl", OAC_CTRL_ADDR, {25'h0, i[2], 4'h0, i[1:0]});
    end
    xfer(1'b1, 8'h0C, 32'hFF);
    chk("unmapped err", e, 1'b1);
    rdc("ctrl kept", OAC_CTRL_ADDR, 32'h43);
    $display("test control done");
    xfer(1'b1, OAC_TRIM_ADDR, 32'h80);
    xfer(1'b1, OAC_TRIM_ADDR, 32'hC0);
    chk("mode ref", {drv.cal_mode_sel, drv.cal_ref_input_sel}, 2'b11);
    sweep(6'h00, 1'b1, v1);
    sweep(6'h3F, 1'b0, v2);
    chk("up code", v1, 6'(TRIP));
    chk("down code", v2, 6'(TRIP - 1));
    c = 6'(({1'b0, v1} + {1'b0, v2}) >> 1);
    xfer(1'b1, OAC_TRIM_ADDR, {24'h0, 2'b11, c});
    chk("final", drv.offset_trim_code, 6'(TRIP - 1));
    xfer(1'b1, OAC_TRIM_ADDR, 32'h3F);
    rdc("trim", OAC_TRIM_ADDR, 32'h3F);
    chk("normal", drv.cal_mode_sel, 1'b0);
    rdc("status", OAC_STAT_ADDR, 32'h1);
    $display("test calibration done");
    close_out();
  end
endmodule
